// ### hw/eic_pkg.sv
// package: constants and types of the two-wire client front end
package eic_pkg;

  // ------------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned PAGE_W     = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned CS_W       = 3;
  localparam logic [3:0]  BIT_ACK    = 4'h8;   // count at the ack clock
  localparam logic [7:0]  COUNT_MAX  = 8'h80;  // page buffer saturation

  // ------------------------------------------------------------------
  // control byte field positions
  // ------------------------------------------------------------------
  localparam int unsigned RW_POS   = 0;
  localparam int unsigned CS_LSB   = 1;
  localparam int unsigned TYPE_LSB = 4;

  // device type code, arbitrary neutral value
  localparam logic [3:0] TYPE_CODE_DFLT = 4'h5;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic              LINE_RST = 1'b1;  // idle bus is high
  localparam logic [ADDR_W-1:0] PTR_RST  = 16'h0000;

  // ------------------------------------------------------------------
  // transfer phases
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_CTRL   = 3'b001,
    PH_ADDR_H = 3'b010,
    PH_ADDR_L = 3'b011,
    PH_WDATA  = 3'b100,
    PH_RDATA  = 3'b101,
    PH_IGNORE = 3'b110
  } eic_phase_t;

  // synchroniser stages for the pins
  typedef struct packed {
    logic            scl_m;
    logic            scl_s;
    logic            scl_p;
    logic            sda_m;
    logic            sda_s;
    logic            sda_p;
    logic            wp_m;
    logic            wp_s;
    logic [CS_W-1:0] cs_m;
    logic [CS_W-1:0] cs_s;
  } eic_sync_t;

  // state of the front end, apart from the page buffer and its read register
  typedef struct packed {
    eic_sync_t         sy;
    eic_phase_t        phase;
    logic [3:0]        cnt;
    logic [7:0]        shift;
    logic [7:0]        tx;
    logic              ack_pend;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] start;
    logic [7:0]        count;
    logic              sda_oe;
    logic              rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic              commit;
    logic [ADDR_W-1:0] commit_addr;
    logic [7:0]        commit_count;
    logic              blocked;
    logic              buf_wr;
    logic [PAGE_W-1:0] buf_idx;
    logic [7:0]        buf_data;
  } eic_state_t;

endpackage

// ### hw/eic_front_end.sv
// module: two-wire client front end of a serial memory
//
// Overview of operation
// - selected only when all chip-select bits match
// - data line only pulled low or released
// - data changes only while clock low
// - write-inhibit high blocks writes, reads unaffected
// - data falling while clock high is start
// - data rising while clock high is stop
// - one bit per clock, sampled clock high
// - overflow keeps last 128 bytes, oldest overwritten
// - every address and data byte acknowledged on ninth clock
// - control byte not acknowledged while programming busy
// - acknowledge holds data low whole clock high
// - host nack on last read byte, line released
// - control byte: type code, then chip selects
// - last control bit: one read, zero write
// - matching control byte acked, mode entered
// - two address bytes follow, high byte first
// - write-inhibit sampled at the ending stop
// - page writes step only low seven pointer bits
`timescale 1ns/10ps
`default_nettype none

module eic_front_end #(
  parameter logic [3:0] TYPE_CODE = eic_pkg::TYPE_CODE_DFLT  // arbitrary value
) (
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe,
  input  wire logic                         chip_sel_in0,
  input  wire logic                         chip_sel_in1,
  input  wire logic                         chip_sel_in2,
  input  wire logic                         write_inhibit_in,
  input  wire logic                         prog_busy_in,
  output logic                              rd_req,
  output logic [eic_pkg::ADDR_W-1:0]        rd_addr,
  input  wire logic [7:0]                   rd_data,
  output logic                              commit,
  output logic [eic_pkg::ADDR_W-1:0]        commit_addr,
  output logic [7:0]                        commit_count,
  output logic                              write_blocked,
  input  wire logic [eic_pkg::PAGE_W-1:0]   buf_rd_idx,
  output logic [7:0]                        buf_rd_data
);
  import eic_pkg::*;

  // ------------------------------------------------------------------
  // state and page buffer
  // ------------------------------------------------------------------
  eic_state_t q;
  eic_state_t d;
  logic [7:0] page_mem [0:PAGE_BYTES-1];
  logic [7:0] buf_rd_q;

  // bus events seen through the synchronised lines
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;

  // step the low page bits only, upper bits stay put
  function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
    page_step = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 7'h01};
  endfunction

  // ------------------------------------------------------------------
  // line conditions
  // ------------------------------------------------------------------
  // edges of the clock line, second stage against its delayed copy
  assign scl_rise = q.sy.scl_s & ~q.sy.scl_p;
  assign scl_fall = ~q.sy.scl_s & q.sy.scl_p;
  // data edges while the clock stays high
  assign start_c  = q.sy.scl_s & q.sy.scl_p & q.sy.sda_p & ~q.sy.sda_s;
  assign stop_c   = q.sy.scl_s & q.sy.scl_p & ~q.sy.sda_p & q.sy.sda_s;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] byte_v;
    logic       type_ok;
    logic       cs_ok;
    byte_v  = 8'h00;
    type_ok = 1'b0;
    cs_ok   = 1'b0;
    d       = q;

    // pulses last one cycle
    d.rd_req  = 1'b0;
    d.commit  = 1'b0;
    d.blocked = 1'b0;
    d.buf_wr  = 1'b0;

    // two-stage synchronisers, then a delayed copy for edges
    d.sy.scl_m = scl_in;
    d.sy.scl_s = q.sy.scl_m;
    d.sy.scl_p = q.sy.scl_s;
    d.sy.sda_m = sda_in;
    d.sy.sda_s = q.sy.sda_m;
    d.sy.sda_p = q.sy.sda_s;
    d.sy.wp_m  = write_inhibit_in;
    d.sy.wp_s  = q.sy.wp_m;
    d.sy.cs_m  = {chip_sel_in2, chip_sel_in1, chip_sel_in0};
    d.sy.cs_s  = q.sy.cs_m;

    if (start_c) begin
      // restart control byte reception from any phase
      d.phase    = PH_CTRL;
      d.cnt      = 4'h0;
      d.ack_pend = 1'b0;
      d.sda_oe   = 1'b0;
    end else if (stop_c) begin
      // a stop ends the operation; page write commits here
      if (q.phase == PH_WDATA && q.count != 8'h00) begin
        if (q.sy.wp_s) begin
          d.blocked = 1'b1;
        end else begin
          d.commit       = 1'b1;
          d.commit_addr  = q.start;
          d.commit_count = q.count;
        end
      end
      d.phase    = PH_IDLE;
      d.cnt      = 4'h0;
      d.ack_pend = 1'b0;
      d.sda_oe   = 1'b0;
    end else if (q.phase == PH_IDLE || q.phase == PH_IGNORE) begin
      // released and deaf until the next start or stop
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.cnt == BIT_ACK) begin
        // ninth clock: ack bit, from us or from the host
        d.cnt      = 4'h0;
        d.ack_pend = 1'b0;
        if (q.phase == PH_RDATA) begin
          if (!q.ack_pend && q.sy.sda_s) begin
            d.phase = PH_IGNORE;
          end else begin
            d.tx  = rd_data;
            d.ptr = q.ptr + 16'h0001;
          end
        end
      end else begin
        // one data bit per clock, taken while the clock is high
        byte_v  = {q.shift[6:0], q.sy.sda_s};
        d.shift = byte_v;
        d.cnt   = q.cnt + 4'h1;
        if (q.cnt == 4'h7) begin
          // byte complete: decode by phase
          case (q.phase)
            PH_CTRL: begin
              type_ok = byte_v[7:TYPE_LSB] == TYPE_CODE;
              cs_ok   = byte_v[TYPE_LSB-1:CS_LSB] == q.sy.cs_s;
              if (type_ok && cs_ok && !prog_busy_in) begin
                d.ack_pend = 1'b1;
                if (byte_v[RW_POS]) begin
                  d.phase   = PH_RDATA;
                  d.rd_req  = 1'b1;
                  d.rd_addr = q.ptr;
                end else begin
                  d.phase = PH_ADDR_H;
                end
              end else begin
                d.phase = PH_IGNORE;
              end
            end
            PH_ADDR_H: begin
              d.ptr[15:8] = byte_v;
              d.ack_pend  = 1'b1;
              d.phase     = PH_ADDR_L;
            end
            PH_ADDR_L: begin
              d.ptr[7:0] = byte_v;
              d.start    = {q.ptr[15:8], byte_v};
              d.count    = 8'h00;
              d.ack_pend = 1'b1;
              d.phase    = PH_WDATA;
            end
            PH_WDATA: begin
              // page slot follows the low pointer bits, wraps at 128
              d.buf_wr   = 1'b1;
              d.buf_idx  = q.ptr[PAGE_W-1:0];
              d.buf_data = byte_v;
              d.ptr      = page_step(q.ptr);
              if (q.count != COUNT_MAX) begin
                d.count = q.count + 8'h01;
              end
              d.ack_pend = 1'b1;
            end
            PH_RDATA: begin
              // fetch the following byte ahead of the host ack
              d.rd_req  = 1'b1;
              d.rd_addr = q.ptr;
            end
            default: begin
              d.phase = PH_IGNORE;
            end
          endcase
        end
      end
    end else if (scl_fall) begin
      // the line only changes while the clock is low
      if (q.cnt == BIT_ACK) begin
        d.sda_oe = q.ack_pend;
      end else if (q.phase == PH_RDATA) begin
        d.sda_oe = ~q.tx[7];
        d.tx     = {q.tx[6:0], 1'b0};
      end else begin
        d.sda_oe = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q              <= '0;
      q.sy.scl_m     <= LINE_RST;
      q.sy.scl_s     <= LINE_RST;
      q.sy.scl_p     <= LINE_RST;
      q.sy.sda_m     <= LINE_RST;
      q.sy.sda_s     <= LINE_RST;
      q.sy.sda_p     <= LINE_RST;
      q.phase        <= PH_IDLE;
      q.ptr          <= PTR_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // page buffer
  // ------------------------------------------------------------------
  // storage holds no control state, so it takes no reset
  always_ff @(posedge clock) begin
    if (q.buf_wr) begin
      page_mem[q.buf_idx] <= q.buf_data;
    end
  end

  // registered read port for the array controller
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buf_rd_q <= 8'h00;
    end else begin
      buf_rd_q <= page_mem[buf_rd_idx];
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // open drain: the level driven is always low
  assign sda_out       = 1'b0;
  assign sda_oe        = q.sda_oe;
  assign rd_req        = q.rd_req;
  assign rd_addr       = q.rd_addr;
  assign commit        = q.commit;
  assign commit_addr   = q.commit_addr;
  assign commit_count  = q.commit_count;
  assign write_blocked = q.blocked;
  assign buf_rd_data   = buf_rd_q;

endmodule

`default_nettype wire

// ### sim/eic_front_end_monitor.sv
// checker: port-level properties of the two-wire client front end
`timescale 1ns/10ps
`default_nettype none
module eic_front_end_monitor (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        prog_busy_in,
  input wire logic        rd_req,
  input wire logic [15:0] rd_addr,
  input wire logic        commit,
  input wire logic [7:0]  commit_count,
  input wire logic        write_blocked
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // --------
  // properties
  // --------
  a_commit_pulse: assert property (commit |=> !commit)
    else $error("commit pulse too long");
  a_commit_excl: assert property (!(commit && write_blocked))
    else $error("commit and blocked together");
  a_count_range: assert property (commit |-> commit_count inside {[8'h01:8'h80]})
    else $error("commit count out of range");
  a_blocked_pulse: assert property (write_blocked |=> !write_blocked)
    else $error("blocked pulse too long");
  a_out_low: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_oe_clk_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data changed outside clock low");
  a_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data moved during clock high");
  a_rd_pulse: assert property (rd_req |=> !rd_req)
    else $error("read request too long");
  a_rd_addr_hold: assert property ($changed(rd_addr) |-> rd_req)
    else $error("read address moved without request");
  a_no_ack_busy: assert property ($rose(sda_oe) |-> !$past(prog_busy_in))
    else $error("answered while busy");
  c_commit: cover property (commit);
  c_blocked: cover property (write_blocked);
  c_read: cover property (rd_req);
  c_ack: cover property ($rose(sda_oe));
endmodule
bind eic_front_end eic_front_end_monitor mon (.clock(clock), .reset(reset),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy_in(prog_busy_in),
  .rd_req(rd_req), .rd_addr(rd_addr), .commit(commit), .commit_count(commit_count),
  .write_blocked(write_blocked));
`default_nettype wire

// ### sim/eic_host_model.sv
// partner: bus host making the bus clock and open-drain data
`timescale 1ns/10ps
`default_nettype none
module eic_host_model (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  // idle bus: both lines high, clock stands still
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // quarter of a 200 ns bus clock period
  task automatic q();
    repeat (2) @(posedge clock);
  endtask
  // one bit, data moved only while clock low
  task automatic xbit(input logic b, output logic r);
    scl <= 1'b0;
    q();
    sda_rel <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
  endtask
  // start from idle or as a repeat
  task automatic start();
    scl <= 1'b0;
    q();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b0;
    q();
    q();
  endtask
  // stop ends every operation
  task automatic stop();
    scl <= 1'b0;
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b1;
    q();
    q();
  endtask
  // byte out, ninth clock for the answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  // byte in, ack low or nack released
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!ack, r);
  endtask
endmodule
`default_nettype wire

// ### sim/test_eic_front_end.sv
// testbench: random and corner bus traffic for the client front end
`timescale 1ns/10ps
`default_nettype none
module test_eic_front_end;
  import eic_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        scl, sda_rel, sda, sda_out, sda_oe, rd_req, commit, blocked;
  logic [2:0]  cs = 3'h0;
  logic        wp = 1'b0;
  logic        busy = 1'b0;
  logic [15:0] rd_addr, c_addr;
  logic [7:0]  rd_data = 8'h00, c_cnt, bdat;
  logic [6:0]  bidx = 7'h00;
  logic [7:0]  pg [128];
  logic [31:0] lfsr = 32'hC3C8;
  int          fails = 0, cmp_count = 0, ncom = 0, nblk = 0;
  eic_front_end dut (.clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_in0(cs[0]), .chip_sel_in1(cs[1]),
    .chip_sel_in2(cs[2]), .write_inhibit_in(wp), .prog_busy_in(busy), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .commit(commit), .commit_addr(c_addr),
    .commit_count(c_cnt), .write_blocked(blocked), .buf_rd_idx(bidx), .buf_rd_data(bdat));
  eic_host_model h (.clock(clock), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  // wired-and data line with pull-up
  assign sda = sda_rel & ~(sda_oe & ~sda_out);
  // --------
  // helpers
  // --------
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic ctl(input logic [2:0] c, input logic rw, output logic ack);
    h.start();
    h.wbyte({TYPE_CODE_DFLT, c, rw}, ack);
  endtask
  // system clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  // array answers with a pattern, pulses counted
  always @(posedge clock) begin
    rd_data <= mem(rd_addr);
    if (commit === 1'b1) ncom++;
    if (blocked === 1'b1) nblk++;
  end
  // cut a hang short
  initial begin
    #2000000;
    fails++;
    give_verdict();
  end
  // --------
  // main sequence
  // --------
  initial begin
    logic        a;
    logic [7:0]  d;
    logic [15:0] ad;
    int          n, ec, eb;
    ec = 0;
    eb = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    d = rnd();
    cs <= d[2:0];
    repeat (8) @(posedge clock);
    // every chip-select code against one random strap pattern, only the match answers
    for (int k = 0; k < 8; k++) begin
      ctl(k[2:0], 1'b0, a);
      chk(a, k[2:0] == cs);
      h.stop();
    end
    h.start();
    h.wbyte({~TYPE_CODE_DFLT, cs, 1'b0}, a);
    chk(a, 1'b0);
    h.stop();
    busy <= 1'b1;
    ctl(cs, 1'b0, a);
    chk(a, 1'b0);
    h.stop();
    busy <= 1'b0;
    // plain, inhibited and overflowing writes
    for (int w = 0; w < 3; w++) begin
      wp <= (w == 1);
      ad = {rnd(), rnd()};
      n = (w == 2) ? 130 : 1 + rnd() % 3;
      ctl(cs, 1'b0, a);
      chk(a, 1'b1);
      h.wbyte(ad[15:8], a);
      h.wbyte(ad[7:0], a);
      chk(a, 1'b1);
      for (int i = 0; i < n; i++) begin
        d = rnd();
        pg[ad[6:0] + i[6:0]] = d;
        h.wbyte(d, a);
        chk(a, 1'b1);
      end
      h.stop();
      wp <= 1'b0;
      repeat (4) @(posedge clock);
      ec += (w != 1);
      eb += (w == 1);
      chk(ncom[15:0], ec[15:0]);
      chk(nblk[15:0], eb[15:0]);
      if (w != 1) begin
        chk(c_addr, ad);
        chk(c_cnt, (n > 128) ? 16'h0080 : n[15:0]);
        for (int j = 0; j < n && j < 128; j++) begin
          @(posedge clock);
          bidx <= ad[6:0] + j[6:0];
          repeat (2) @(posedge clock);
          #1;
          chk(bdat, pg[ad[6:0] + j[6:0]]);
        end
      end
    end
    // aborted byte, address set, repeated start, two reads
    for (int r = 0; r < 2; r++) begin
      ad = r ? {rnd(), rnd()} : 16'hFFFF;
      wp <= r[0];
      h.start();
      h.xbit(1'b1, a);
      h.xbit(1'b0, a);
      ctl(cs, 1'b0, a);
      chk(a, 1'b1);
      h.wbyte(ad[15:8], a);
      h.wbyte(ad[7:0], a);
      ctl(cs, 1'b1, a);
      chk(a, 1'b1);
      h.rbyte(1'b1, d);
      chk(d, mem(ad));
      h.rbyte(1'b0, d);
      chk(d, mem(ad + 16'h0001));
      chk(sda, 1'b1);
      h.stop();
    end
    wp <= 1'b0;
    repeat (4) @(posedge clock);
    chk(ncom[15:0], ec[15:0]);
    chk(nblk[15:0], eb[15:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
